//--- rtl/cwd_config_word.sv
// Configuration word store with programming-port access and decoded setting outputs
`timescale 1ns/1ps

module cwd_config_word #(
    parameter cwd_pkg::cwd_layout_e  LAYOUT  = cwd_pkg::CWD_LAY_REPL,
    parameter cwd_pkg::cwd_memsize_e MEMSIZE = cwd_pkg::CWD_MEM_FULL
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   cfg_region,
    input  wire logic [13:0]            prog_addr,
    input  wire logic [13:0]            prog_wdata,
    input  wire logic                   prog_write,
    input  wire logic                   prog_read,
    input  wire logic [12:0]            write_target,
    output logic      [13:0]            prog_rdata,
    output logic                        prog_rvalid,
    output logic                        target_locked,
    output cwd_pkg::cwd_settings_s      settings
);

    // ==========================================================
    // Layout mask
    localparam logic [13:0] IMPL_MASK =
        (LAYOUT == cwd_pkg::CWD_LAY_SINGLE)     ? cwd_pkg::CWD_MASK_SINGLE :
        (LAYOUT == cwd_pkg::CWD_LAY_DUAL)       ? cwd_pkg::CWD_MASK_DUAL   :
        (LAYOUT == cwd_pkg::CWD_LAY_ONEBIT)     ? cwd_pkg::CWD_MASK_ONEBIT :
        (LAYOUT == cwd_pkg::CWD_LAY_BORLVL)     ? cwd_pkg::CWD_MASK_BORLVL :
        (LAYOUT == cwd_pkg::CWD_LAY_REPL_NOBOR) ? cwd_pkg::CWD_MASK_NOBOR  :
                                                  cwd_pkg::CWD_MASK_REPL;

    // ==========================================================
    // Access decode
    // Word is only reachable once the programmer has moved into the configuration region
    wire logic hit_word = cfg_region && (prog_addr == cwd_pkg::CWD_WORD_ADDR);
    wire logic do_write = hit_word & prog_write;
    wire logic do_read  = hit_word & prog_read;

    // One-time programmable cells can only move 1 to 0, so a write ANDs in
    logic [13:0] word_r;
    wire  logic [13:0] word_nxt = word_r & prog_wdata;
    // Unimplemented positions forced high on every view of the word
    wire  logic [13:0] word_view = word_r | ~IMPL_MASK;

    // ==========================================================
    // Decode
    cwd_pkg::cwd_settings_s dec;

    cwd_field_decode #(
        .LAYOUT  (LAYOUT),
        .MEMSIZE (MEMSIZE)
    ) u_decode (
        .word     (word_view),
        .settings (dec)
    );

    // Write-lock check of a user address against the decoded protection region
    localparam logic [12:0] TOP =
        (MEMSIZE == cwd_pkg::CWD_MEM_HALFK) ? 13'h01FF :
        (MEMSIZE == cwd_pkg::CWD_MEM_1K)    ? 13'h03FF : 13'h1FFF;
    wire logic [12:0] half_base = (TOP >> 1) + 13'h0001;
    wire logic [12:0] q3_base   = (TOP >> 2) + 13'h0001;
    logic locked_nxt;
    always_comb
    begin
        case (dec.prot)
            cwd_pkg::CWD_PROT_UPPER_HALF:  locked_nxt = (write_target >= half_base);
            cwd_pkg::CWD_PROT_UPPER_3Q:    locked_nxt = (write_target >= q3_base);
            cwd_pkg::CWD_PROT_ALL:         locked_nxt = 1'b1;
            cwd_pkg::CWD_PROT_ALL_BUT_LOW:
                locked_nxt = (write_target > cwd_pkg::CWD_OPEN_LAST);
            default:                       locked_nxt = 1'b0;
        endcase
    end

    // ==========================================================
    // Registers; settings and target_locked follow the stored word one cycle later, prog_rdata is loaded only on a read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            word_r <= cwd_pkg::CWD_ERASED;
        else if (do_write)
            word_r <= word_nxt;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_rdata    <= 14'h0000;
            prog_rvalid   <= 1'b0;
            target_locked <= 1'b0;
            settings      <= '0;
        end
        else
        begin
            prog_rvalid   <= do_read;
            if (do_read)
                prog_rdata <= word_view;
            target_locked <= locked_nxt;
            settings      <= dec;
        end
    end

endmodule

//--- rtl/cwd_pkg.sv
// Package for the configuration word decoder: layouts, field positions, decoded settings
package cwd_pkg;

    // ==========================================================
    // Word geometry
    localparam int          CWD_WORD_W       = 14;
    localparam logic [13:0] CWD_WORD_ADDR    = 14'h2007;
    localparam logic [13:0] CWD_CFG_BASE     = 14'h2000;
    localparam logic [13:0] CWD_ERASED       = 14'h3FFF;

    // ==========================================================
    // Field positions
    localparam int CWD_OSC_LO     = 0;
    localparam int CWD_WDT_BIT    = 2;
    localparam int CWD_POWERUP_DELAY_TIMER_BIT   = 3;
    localparam int CWD_CP_LO      = 4;
    localparam int CWD_BOR_BIT    = 6;
    localparam int CWD_CP_PAIR_HI = 12;
    localparam int CWD_CP_PAIR_MD = 10;
    localparam int CWD_CP_PAIR_LO = 8;

    // ==========================================================
    // Implemented-bit masks per layout; others read as 1
    localparam logic [13:0] CWD_MASK_SINGLE = 14'h001F;
    localparam logic [13:0] CWD_MASK_DUAL   = 14'h003F;
    localparam logic [13:0] CWD_MASK_REPL   = 14'h3F7F;
    localparam logic [13:0] CWD_MASK_ONEBIT = 14'h3FFF;
    localparam logic [13:0] CWD_MASK_BORLVL = 14'h3F7F;
    localparam logic [13:0] CWD_MASK_NOBOR  = 14'h3F3F;

    // Writable window: under single-bit protection these low addresses stay open
    localparam logic [12:0] CWD_OPEN_LAST   = 13'h003F;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        CWD_LAY_SINGLE,
        CWD_LAY_DUAL,
        CWD_LAY_REPL,
        CWD_LAY_ONEBIT,
        CWD_LAY_BORLVL,
        CWD_LAY_REPL_NOBOR
    } cwd_layout_e;

    typedef enum logic [1:0] {
        CWD_MEM_FULL,
        CWD_MEM_1K,
        CWD_MEM_HALFK
    } cwd_memsize_e;

    typedef enum logic [2:0] {
        CWD_PROT_NONE,
        CWD_PROT_UPPER_HALF,
        CWD_PROT_UPPER_3Q,
        CWD_PROT_ALL,
        CWD_PROT_ALL_BUT_LOW
    } cwd_prot_e;

    typedef enum logic [1:0] {
        CWD_OSC_LP,
        CWD_OSC_XT,
        CWD_OSC_HS,
        CWD_OSC_RC
    } cwd_osc_e;

    typedef struct packed {
        cwd_prot_e   prot;
        logic        prot_valid;
        logic        powerup_delay_timer;
        logic        watchdog_timer;
        logic        brownout_reset;
        cwd_osc_e    osc;
    } cwd_settings_s;

endpackage

//--- rtl/cwd_field_decode.sv
// Combinational decode of a stored configuration word into device settings
`timescale 1ns/1ps

module cwd_field_decode #(
    parameter cwd_pkg::cwd_layout_e  LAYOUT  = cwd_pkg::CWD_LAY_REPL,
    parameter cwd_pkg::cwd_memsize_e MEMSIZE = cwd_pkg::CWD_MEM_FULL
) (
    input  wire logic [13:0]           word,
    output cwd_pkg::cwd_settings_s     settings
);

    // ==========================================================
    // Protection field and agreement of replicas
    wire logic [1:0] protect_level_field = word[cwd_pkg::CWD_CP_LO +: 2];
    wire logic       protect_bit_low     = protect_level_field[0];
    wire logic       protect_bit_high    = protect_level_field[1];

    wire logic pairs_same =
        (word[cwd_pkg::CWD_CP_PAIR_HI +: 2] == protect_level_field) &&
        (word[cwd_pkg::CWD_CP_PAIR_MD +: 2] == protect_level_field) &&
        (word[cwd_pkg::CWD_CP_PAIR_LO +: 2] == protect_level_field);
    // Bits 13-7 plus 5-4 must all carry one value
    wire logic onebit_same = (&{word[13:7], word[5:4]}) || ~(|{word[13:7], word[5:4]});
    // Brown-out-level layout repeats only the pair at 13-12 and 9-8
    wire logic borlvl_same =
        (word[cwd_pkg::CWD_CP_PAIR_HI +: 2] == protect_level_field) &&
        (word[cwd_pkg::CWD_CP_PAIR_LO +: 2] == protect_level_field);

    wire logic is_repl   = (LAYOUT == cwd_pkg::CWD_LAY_REPL) ||
                           (LAYOUT == cwd_pkg::CWD_LAY_REPL_NOBOR);
    wire logic has_bor   = (LAYOUT == cwd_pkg::CWD_LAY_REPL) ||
                           (LAYOUT == cwd_pkg::CWD_LAY_ONEBIT) ||
                           (LAYOUT == cwd_pkg::CWD_LAY_BORLVL);
    wire logic old_powerup_delay_timer  = (LAYOUT == cwd_pkg::CWD_LAY_SINGLE) ||
                           (LAYOUT == cwd_pkg::CWD_LAY_DUAL);

    // Disagreeing replicas leave the part unprotected; no scheme applies
    wire logic prot_ok = is_repl ? pairs_same :
                         (LAYOUT == cwd_pkg::CWD_LAY_ONEBIT) ? onebit_same :
                         (LAYOUT == cwd_pkg::CWD_LAY_BORLVL) ? borlvl_same : 1'b1;

    // ==========================================================
    // Level decode per layout and memory size
    cwd_pkg::cwd_prot_e level;
    always_comb
    begin
        level = cwd_pkg::CWD_PROT_NONE;
        case (LAYOUT)
            cwd_pkg::CWD_LAY_SINGLE:
                level = protect_bit_low ? cwd_pkg::CWD_PROT_NONE : cwd_pkg::CWD_PROT_ALL;
            cwd_pkg::CWD_LAY_ONEBIT:
                level = protect_bit_low ? cwd_pkg::CWD_PROT_NONE
                                        : cwd_pkg::CWD_PROT_ALL_BUT_LOW;
            default:
            begin
                if (MEMSIZE == cwd_pkg::CWD_MEM_HALFK)
                    level = (protect_level_field == 2'h0) ? cwd_pkg::CWD_PROT_ALL
                                                          : cwd_pkg::CWD_PROT_NONE;
                else if (MEMSIZE == cwd_pkg::CWD_MEM_1K)
                    level = protect_bit_high ? cwd_pkg::CWD_PROT_NONE :
                            protect_bit_low  ? cwd_pkg::CWD_PROT_UPPER_HALF
                                             : cwd_pkg::CWD_PROT_ALL;
                else
                    case (protect_level_field)
                        2'h3:    level = cwd_pkg::CWD_PROT_NONE;
                        2'h2:    level = cwd_pkg::CWD_PROT_UPPER_HALF;
                        2'h1:    level = cwd_pkg::CWD_PROT_UPPER_3Q;
                        default: level = cwd_pkg::CWD_PROT_ALL;
                    endcase
            end
        endcase
    end

    // ==========================================================
    // Timer, watchdog, brown-out, oscillator
    wire logic brownout_enable          = has_bor & word[cwd_pkg::CWD_BOR_BIT];
    wire logic powerup_delay_enable     = ~word[cwd_pkg::CWD_POWERUP_DELAY_TIMER_BIT];
    wire logic powerup_delay_enable_alt = word[cwd_pkg::CWD_POWERUP_DELAY_TIMER_BIT];
    wire logic powerup_delay_timer_sel = old_powerup_delay_timer ? powerup_delay_enable_alt : powerup_delay_enable;

    assign settings.prot                = prot_ok ? level : cwd_pkg::CWD_PROT_NONE;
    assign settings.prot_valid          = prot_ok;
    assign settings.powerup_delay_timer = powerup_delay_timer_sel | brownout_enable;
    assign settings.watchdog_timer      = word[cwd_pkg::CWD_WDT_BIT];
    assign settings.brownout_reset      = brownout_enable;
    assign settings.osc = cwd_pkg::cwd_osc_e'(word[cwd_pkg::CWD_OSC_LO +: 2]);

endmodule

//--- sim/cwd_prog_model.sv
// Programmer model that drives the configuration word port
`timescale 1ns/1ps
module cwd_prog_model #(
    parameter int SUPPLY_MIN_LEVEL = 1,
    parameter int SUPPLY_MAX_LEVEL = 2
) (
    input  wire logic        mclk,
    output logic             cfg_region,
    output logic [13:0]      prog_addr,
    output logic [13:0]      prog_wdata,
    output logic             prog_write,
    output logic             prog_read,
    input  wire logic [13:0] prog_rdata,
    input  wire logic        prog_rvalid
);
    int supply_level;
    initial
    begin
        {cfg_region, prog_write, prog_read} = 3'h0;
        prog_addr = 14'h0000;
        prog_wdata = 14'h2AAA;
        supply_level = SUPPLY_MIN_LEVEL;
    end
    // ==========================================================
    // One access; the region flag is driven from cfg with the address
    task automatic xfer(input logic wr, input logic cfg, input logic [13:0] a,
                        input logic [13:0] d, output logic [13:0] r, output logic v);
        @(posedge mclk);
        cfg_region <= cfg;
        prog_addr <= a;
        prog_wdata <= d;
        prog_write <= wr;
        prog_read <= !wr;
        @(posedge mclk);
        prog_write <= 1'b0;
        prog_read <= 1'b0;
        // Released data never keeps its last value
        prog_wdata <= ~d;
        #1;
        r = prog_rdata;
        v = prog_rvalid;
    endtask
    // Verify at both supply limits; limits are user parameters
    task automatic verify(output logic [13:0] r_min, output logic [13:0] r_max);
        logic v;
        supply_level = SUPPLY_MIN_LEVEL;
        xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r_min, v);
        supply_level = SUPPLY_MAX_LEVEL;
        xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r_max, v);
    endtask
endmodule

//--- sim/cwd_config_word_chk.sv
// Assertion checker for the configuration word store
`timescale 1ns/1ps
module cwd_config_word_chk #(
    parameter cwd_pkg::cwd_layout_e  LAYOUT  = cwd_pkg::CWD_LAY_REPL,
    parameter cwd_pkg::cwd_memsize_e MEMSIZE = cwd_pkg::CWD_MEM_FULL
) (
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic                   cfg_region,
    input wire logic [13:0]            prog_addr,
    input wire logic                   prog_write,
    input wire logic                   prog_read,
    input wire logic [12:0]            write_target,
    input wire logic [13:0]            prog_rdata,
    input wire logic                   prog_rvalid,
    input wire logic                   target_locked,
    input wire cwd_pkg::cwd_settings_s settings
);
    localparam bit OLD = LAYOUT == cwd_pkg::CWD_LAY_SINGLE || LAYOUT == cwd_pkg::CWD_LAY_DUAL;
    localparam bit HAS_BOR = !OLD && LAYOUT != cwd_pkg::CWD_LAY_REPL_NOBOR;
    localparam logic [13:0] MASK = LAYOUT == cwd_pkg::CWD_LAY_SINGLE ? 14'h001F :
        LAYOUT == cwd_pkg::CWD_LAY_DUAL ? 14'h003F : LAYOUT == cwd_pkg::CWD_LAY_ONEBIT ?
        14'h3FFF : LAYOUT == cwd_pkg::CWD_LAY_REPL_NOBOR ? 14'h3F3F : 14'h3F7F;
    logic [1:0] up_r;
    wire acc = cfg_region && prog_addr == 14'h2007;
    wire acc_wr = acc && prog_write;
    wire acc_rd = acc && prog_read;
    // Stability checks wait until the first decode after reset has landed
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence quiet_s;
        !acc_wr && $stable(write_target);
    endsequence
    // ==========================================================
    // Assertions
    rvalid_after_read_a: assert property (acc_rd |=> prog_rvalid)
        else $error("read not answered next cycle");
    rvalid_only_read_a: assert property (!acc_rd |=> !prog_rvalid)
        else $error("answer without accepted read");
    unimpl_ones_a: assert property (prog_rvalid |-> (prog_rdata | MASK) == 14'h3FFF)
        else $error("unimplemented bit read as 0");
    bor_powerup_delay_timer_a: assert property (
        settings.brownout_reset |-> settings.powerup_delay_timer)
        else $error("brown-out on but power-up timer off");
    bits_follow_a: assert property (
        prog_rvalid |-> settings.watchdog_timer == prog_rdata[2]
        && settings.osc == cwd_pkg::cwd_osc_e'(prog_rdata[1:0]))
        else $error("wdt or osc decode wrong");
    powerup_delay_timer_polarity_a: assert property (
        prog_rvalid |-> settings.powerup_delay_timer ==
        ((OLD ? prog_rdata[3] : !prog_rdata[3]) || (HAS_BOR && prog_rdata[6])))
        else $error("power-up timer decode wrong");
    bor_bit_a: assert property (
        prog_rvalid |-> settings.brownout_reset == (HAS_BOR && prog_rdata[6]))
        else $error("brown-out decode wrong");
    quiet_stable_a: assert property (
        (up_r == 2'h3 && !acc_wr && $stable(write_target)) ##1 quiet_s
        |=> $stable(target_locked) && $stable(settings))
        else $error("outputs moved without cause");
    prot_all_locks_a: assert property (
        settings.prot == cwd_pkg::CWD_PROT_ALL |-> target_locked)
        else $error("full protection left address open");
    prot_none_free_a: assert property (
        settings.prot == cwd_pkg::CWD_PROT_NONE |-> !target_locked)
        else $error("address locked without protection");
endmodule
bind cwd_config_word cwd_config_word_chk #(.LAYOUT(LAYOUT), .MEMSIZE(MEMSIZE)) chk_i (
    .mclk, .rst_n,
    .cfg_region, .prog_addr, .prog_write, .prog_read, .write_target, .prog_rdata, .prog_rvalid,
    .target_locked, .settings);

//--- sim/tb.sv
// Self-checking testbench for the configuration word store
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [12:0] write_target = 13'h0000;
    wire cfg_region, prog_write, prog_read, prog_rvalid, target_locked;
    wire [13:0] prog_addr, prog_wdata, prog_rdata;
    cwd_pkg::cwd_settings_s settings;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2.5 mclk = ~mclk;
    cwd_prog_model prog (.mclk, .cfg_region, .prog_addr, .prog_wdata, .prog_write, .prog_read,
        .prog_rdata, .prog_rvalid);
    cwd_config_word #(.LAYOUT(cwd_pkg::CWD_LAY_REPL), .MEMSIZE(cwd_pkg::CWD_MEM_FULL)) uut (.mclk,
        .rst_n, .cfg_region, .prog_addr, .prog_wdata, .prog_write, .prog_read, .write_target,
        .prog_rdata, .prog_rvalid, .target_locked, .settings);
    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic cwd_pkg::cwd_settings_s exp_set(input logic [13:0] w);
        cwd_pkg::cwd_settings_s s;
        s.prot_valid = w[13:12] == w[5:4] && w[11:10] == w[5:4] && w[9:8] == w[5:4];
        s.prot = (!s.prot_valid || w[5:4] == 2'h3) ? cwd_pkg::CWD_PROT_NONE :
            w[5:4] == 2'h2 ? cwd_pkg::CWD_PROT_UPPER_HALF :
            w[5:4] == 2'h1 ? cwd_pkg::CWD_PROT_UPPER_3Q : cwd_pkg::CWD_PROT_ALL;
        s.powerup_delay_timer = !w[3] || w[6];
        s.watchdog_timer = w[2];
        s.brownout_reset = w[6];
        s.osc = cwd_pkg::cwd_osc_e'(w[1:0]);
        return s;
    endfunction
    // 8K part: upper half starts at 1000h, upper three quarters at 0800h
    function automatic logic [15:0] exp_lock(input cwd_pkg::cwd_prot_e p, input logic [12:0] t);
        return {15'h0000, p == cwd_pkg::CWD_PROT_ALL ||
            (p == cwd_pkg::CWD_PROT_UPPER_HALF && t >= 13'h1000) ||
            (p == cwd_pkg::CWD_PROT_UPPER_3Q && t >= 13'h0800)};
    endfunction
    task automatic do_reset(input logic [12:0] tgt);
        @(posedge mclk);
        rst_n <= 1'b0;
        write_target <= tgt;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_erased;
        logic [13:0] r0, r1;
        do_reset(13'h0040);
        prog.verify(r0, r1);
        chk("rdata_min", r0, 16'h3FFF);
        chk("rdata_max", r1, 16'h3FFF);
        chk("erased_set", settings, exp_set(14'h3FFF));
        chk("erased_lock", target_locked, 16'h0000);
    endtask
    task automatic t_decode;
        logic [13:0] words [5] = '{14'h3F7E, 14'h2A29, 14'h1514, 14'h004B, 14'h3F4F};
        // Window edges and the top address, so each level meets its boundary
        logic [12:0] tgts [5] = '{13'h0040, 13'h1000, 13'h0800, 13'h0000, 13'h1FFF};
        logic [13:0] r;
        logic v;
        cwd_pkg::cwd_settings_s e;
        foreach (words[i])
        begin
            do_reset(tgts[i]);
            prog.xfer(1'b1, 1'b1, 14'h2007, words[i], r, v);
            repeat (2) @(posedge mclk);
            #1;
            e = exp_set(words[i]);
            chk("settings", settings, e);
            chk("locked", target_locked, exp_lock(e.prot, tgts[i]));
            prog.xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r, v);
            chk("readback", r, words[i] | 14'h0080);
        end
    endtask
    task automatic t_refused;
        logic [13:0] r;
        logic v;
        do_reset(13'h0000);
        // User region first: xfer sets cfg_region on every access, low for the first two here
        prog.xfer(1'b1, 1'b0, 14'h2007, 14'h0000, r, v);
        prog.xfer(1'b0, 1'b0, 14'h2007, 14'h0000, r, v);
        chk("no_region_rvalid", v, 16'h0000);
        prog.xfer(1'b1, 1'b1, 14'h2006, 14'h0000, r, v);
        prog.xfer(1'b0, 1'b1, 14'h2000, 14'h0000, r, v);
        chk("wrong_addr_rvalid", v, 16'h0000);
        prog.xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r, v);
        chk("untouched", {v, r}, 16'h7FFF);
    endtask
    task automatic t_program_only_clears;
        logic [13:0] r;
        logic v;
        do_reset(13'h1FFF);
        prog.xfer(1'b1, 1'b1, 14'h2007, 14'h3F7E, r, v);
        prog.xfer(1'b1, 1'b1, 14'h2007, 14'h3FFD, r, v);
        prog.xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r, v);
        chk("and_word", r, 16'h3FFC);
        do_reset(13'h1FFF);
        prog.xfer(1'b0, 1'b1, 14'h2007, 14'h0000, r, v);
        chk("reerased", r, 16'h3FFF);
    endtask
    // ==========================================================
    // Sequencing, hang limit and verdict
    task automatic wrap_up;
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        t_erased();
        t_decode();
        t_refused();
        t_program_only_clears();
        wrap_up();
    end
endmodule
